// >>> pkg/albo_pkg.sv
/*
 * constants for the accumulator/file-register execution datapath:
 * operation codes, flag positions, register map and reset values.
 * assumes: a single 20 mhz system clock and a classic wishbone master.
 */
`default_nettype none

package albo_pkg;
    // operation selector
    typedef enum logic [2:0]
    {
        ALBO_OP_NONE = 3'h0,
        ALBO_OP_ADD_FILE = 3'h1,
        ALBO_OP_AND_LIT = 3'h2,
        ALBO_OP_AND_FILE = 3'h3,
        ALBO_OP_CLR_BIT = 3'h4,
        ALBO_OP_SET_BIT = 3'h5,
        ALBO_OP_TEST_SKIP = 3'h6
    } albo_op_t;

    // word register offsets (byte addresses)
    localparam logic [7:0] ALBO_OFF_CMD = 8'h00;
    localparam logic [7:0] ALBO_OFF_ACCUM = 8'h04;
    localparam logic [7:0] ALBO_OFF_FLAGS = 8'h08;
    localparam logic [7:0] ALBO_OFF_FILE_BASE = 8'h80;

    // command word fields
    localparam int ALBO_CMD_OP_LSB = 0;
    localparam int ALBO_CMD_DEST_BIT = 3;
    localparam int ALBO_CMD_BIT_LSB = 4;
    localparam int ALBO_CMD_ADDR_LSB = 8;
    localparam int ALBO_CMD_LIT_LSB = 16;

    // flag register fields
    localparam int ALBO_FLAG_CARRY = 0;
    localparam int ALBO_FLAG_DIGIT = 1;
    localparam int ALBO_FLAG_ZERO = 2;
    localparam int ALBO_FLAG_SKIP = 3;

    // reset values
    localparam logic [7:0] ALBO_RST_ACCUM = 8'h00;
    localparam logic [2:0] ALBO_RST_FLAGS = 3'h0;
    localparam logic [7:0] ALBO_RST_FILE = 8'h00;

    // cycles a skipping bit test occupies
    localparam logic [1:0] ALBO_SKIP_CYCLES = 2'h2;
endpackage : albo_pkg

`default_nettype wire

// >>> pkg/albo_alu_if.sv
/*
 * carrier between the top module and the combinational alu.
 * assumes: the top drives operands, the alu returns result and flags.
 */
`timescale 1ns/1ns
`default_nettype none

interface albo_alu_if;
    albo_pkg::albo_op_t op; // operation in execution
    logic [7:0] accum; // accumulator operand
    logic [7:0] file_val; // addressed file register
    logic [7:0] literal; // immediate operand
    logic [2:0] bit_sel; // bit position
    logic [7:0] result; // 8-bit result
    logic carry; // carry out of bit 7
    logic digit; // carry out of bit 3
    logic zero; // result is zero
    logic bit_clear; // tested bit reads zero

    modport top
    (
        output op, accum, file_val, literal, bit_sel,
        input result, carry, digit, zero, bit_clear
    );
    modport alu
    (
        input op, accum, file_val, literal, bit_sel,
        output result, carry, digit, zero, bit_clear
    );
endinterface : albo_alu_if

`default_nettype wire

// >>> hdl/albo_alu.sv
/*
 * combinational arithmetic and logic unit for add, and, bit operations.
 * assumes: operands steady for the cycle; results sampled by the caller.
 */
`timescale 1ns/1ns
`default_nettype none

module albo_alu
(
    albo_alu_if.alu bus
);
    logic [4:0] low_sum; // low nibble sum, bit 4 is digit carry
    logic [8:0] full_sum; // full sum, bit 8 is carry
    logic [7:0] bit_mask; // one-hot mask for the bit position

    // arithmetic and mask generation
    always_comb
    begin
        low_sum = {1'b0, bus.accum[3:0]} + {1'b0, bus.file_val[3:0]};
        full_sum = {1'b0, bus.accum} + {1'b0, bus.file_val};
        bit_mask = 8'h01 << bus.bit_sel;
    end

    // result selection per operation
    always_comb
    begin
        bus.result = 8'h00;
        case (bus.op)
            albo_pkg::ALBO_OP_ADD_FILE:
                bus.result = full_sum[7:0]; // [RULE1]
            albo_pkg::ALBO_OP_AND_LIT:
                bus.result = bus.accum & bus.literal; // [RULE2]
            albo_pkg::ALBO_OP_AND_FILE:
                bus.result = bus.accum & bus.file_val; // [RULE3]
            albo_pkg::ALBO_OP_CLR_BIT:
                bus.result = bus.file_val & ~bit_mask; // [RULE4]
            albo_pkg::ALBO_OP_SET_BIT:
                bus.result = bus.file_val | bit_mask; // [RULE5]
            default:
                bus.result = bus.file_val;
        endcase
    end

    // flag outputs; the caller decides which flags are written
    always_comb
    begin
        bus.carry = full_sum[8]; // [RULE7]
        bus.digit = low_sum[4]; // [RULE7]
        bus.zero = (bus.result == 8'h00); // [RULE7]
        bus.bit_clear = ((bus.file_val & bit_mask) == 8'h00); // [RULE6]
    end
endmodule : albo_alu

`default_nettype wire

// >>> hdl/albo_core.sv
/*
 * execution datapath: accumulator, file registers, status flags and the
 * skip state, reached over a classic wishbone slave.
 * assumes: one 20 mhz clock, synchronous active-high reset, and a master
 * that holds each request until it sees ack.
 */
// The register addresses and register access over Wishbone are this design's own decisions.
// Notes on behaviour
// [RULE1] add accumulator and file, choose destination
// [RULE2] and literal into accumulator, zero only
// [RULE3] and accumulator with file, zero only
// [RULE4] clear one file bit, flags untouched
// [RULE5] set one file bit, flags untouched
// [RULE6] bit clear: discard next, execute no-op
// [RULE7] zero on zero result, carries from adder
`timescale 1ns/1ns
`default_nettype none

module albo_core
#(
    parameter int FILE_DEPTH = 32 // file registers, addresses 0 to 31
)
(
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic [7:0] ACCUM,
    output logic [2:0] FLAGS,
    output logic SKIP_ACTIVE
);
    localparam int AW = $clog2(FILE_DEPTH);

    logic [7:0] accum; // accumulator
    logic carry_flag; // carry out of bit 7
    logic digit_carry_flag; // carry out of bit 3
    logic zero_flag; // zero result
    logic [7:0] file_reg [FILE_DEPTH]; // file register array
    logic skip_pending; // next command is discarded
    logic [1:0] skip_cycles; // cycles of the current test
    logic ack; // one-cycle ack

    logic req; // new bus request this cycle
    logic cmd_wr; // write to command register
    logic file_hit; // address inside the file window
    logic [AW-1:0] file_idx; // file index from bus address
    albo_pkg::albo_op_t cmd_op; // operation decoded from write data
    logic cmd_dest; // 1: result to file, 0: to accumulator
    logic [2:0] cmd_bit; // bit position
    logic [AW-1:0] cmd_addr; // file address of the command
    logic exec; // command really executes
    logic [31:0] next_dat; // read data to register

    albo_alu_if alu_bus ();

    albo_alu u_alu
    (
        .bus(alu_bus)
    );

    // request decode; ack drops in the cycle after it was given
    always_comb
    begin
        req = WB_CYC_I && WB_STB_I && !ack;
        cmd_wr = req && WB_WE_I && WB_SEL_I[0]
            && (WB_ADR_I == albo_pkg::ALBO_OFF_CMD);
        file_hit = (WB_ADR_I >= albo_pkg::ALBO_OFF_FILE_BASE)
            && ((WB_ADR_I - albo_pkg::ALBO_OFF_FILE_BASE)
                < 8'(FILE_DEPTH * 4));
        file_idx = AW'((WB_ADR_I - albo_pkg::ALBO_OFF_FILE_BASE) >> 2);
        cmd_op = albo_pkg::albo_op_t'(
            WB_DAT_I[albo_pkg::ALBO_CMD_OP_LSB +: 3]);
        cmd_dest = WB_DAT_I[albo_pkg::ALBO_CMD_DEST_BIT];
        cmd_bit = WB_DAT_I[albo_pkg::ALBO_CMD_BIT_LSB +: 3];
        cmd_addr = WB_DAT_I[albo_pkg::ALBO_CMD_ADDR_LSB +: AW];
        // a command landing in the skip slot is swallowed as a no-op
        exec = cmd_wr && !skip_pending; // [RULE6]
    end

    // operands to the alu
    always_comb
    begin
        alu_bus.op = cmd_op;
        alu_bus.accum = accum;
        alu_bus.file_val = file_reg[cmd_addr];
        alu_bus.literal = WB_DAT_I[albo_pkg::ALBO_CMD_LIT_LSB +: 8];
        alu_bus.bit_sel = cmd_bit;
    end

    // bus ack, one cycle after each request
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
            ack <= 1'b0;
        else
            ack <= req;
    end

    // accumulator updates
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
            accum <= albo_pkg::ALBO_RST_ACCUM;
        else if (exec)
        begin
            case (cmd_op)
                albo_pkg::ALBO_OP_ADD_FILE,
                albo_pkg::ALBO_OP_AND_FILE:
                    if (!cmd_dest)
                        accum <= alu_bus.result; // [RULE1] [RULE3]
                albo_pkg::ALBO_OP_AND_LIT:
                    accum <= alu_bus.result; // [RULE2]
                default:
                    accum <= accum;
            endcase
        end
        else if (req && WB_WE_I && WB_SEL_I[0]
            && WB_ADR_I == albo_pkg::ALBO_OFF_ACCUM)
            accum <= WB_DAT_I[7:0]; // direct load by software
    end

    // status flags: each operation writes only its own flags
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            carry_flag <= albo_pkg::ALBO_RST_FLAGS[albo_pkg::ALBO_FLAG_CARRY];
            digit_carry_flag <=
                albo_pkg::ALBO_RST_FLAGS[albo_pkg::ALBO_FLAG_DIGIT];
            zero_flag <= albo_pkg::ALBO_RST_FLAGS[albo_pkg::ALBO_FLAG_ZERO];
        end
        else if (exec)
        begin
            case (cmd_op)
                albo_pkg::ALBO_OP_ADD_FILE:
                begin
                    carry_flag <= alu_bus.carry; // [RULE1] [RULE7]
                    digit_carry_flag <= alu_bus.digit; // [RULE7]
                    zero_flag <= alu_bus.zero; // [RULE7]
                end
                albo_pkg::ALBO_OP_AND_LIT,
                albo_pkg::ALBO_OP_AND_FILE:
                    zero_flag <= alu_bus.zero; // [RULE2] [RULE3]
                default: // bit ops leave flags alone
                    zero_flag <= zero_flag; // [RULE4] [RULE5] [RULE6]
            endcase
        end
        else if (req && WB_WE_I && WB_SEL_I[0]
            && WB_ADR_I == albo_pkg::ALBO_OFF_FLAGS)
        begin
            carry_flag <= WB_DAT_I[albo_pkg::ALBO_FLAG_CARRY];
            digit_carry_flag <= WB_DAT_I[albo_pkg::ALBO_FLAG_DIGIT];
            zero_flag <= WB_DAT_I[albo_pkg::ALBO_FLAG_ZERO];
        end
    end

    // file array: one write port shared by commands and direct access
    genvar gi;
    generate
        for (gi = 0; gi < FILE_DEPTH; gi++)
        begin : g_file
            always_ff @(posedge CLK_SYS)
            begin
                if (SYS_RST)
                    file_reg[gi] <= albo_pkg::ALBO_RST_FILE;
                else if (exec && cmd_addr == AW'(gi))
                begin
                    case (cmd_op)
                        albo_pkg::ALBO_OP_ADD_FILE,
                        albo_pkg::ALBO_OP_AND_FILE:
                            if (cmd_dest)
                                file_reg[gi] <= alu_bus.result; // [RULE1]
                        albo_pkg::ALBO_OP_CLR_BIT,
                        albo_pkg::ALBO_OP_SET_BIT:
                            file_reg[gi] <= alu_bus.result; // [RULE4] [RULE5]
                        default:
                            file_reg[gi] <= file_reg[gi];
                    endcase
                end
                else if (!cmd_wr && req && WB_WE_I && WB_SEL_I[0]
                    && file_hit && file_idx == AW'(gi))
                    file_reg[gi] <= WB_DAT_I[7:0];
            end
        end
    endgenerate

    // skip state: a clear tested bit discards the next command
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            skip_pending <= 1'b0;
            skip_cycles <= 2'h0;
        end
        else if (cmd_wr && skip_pending)
        begin
            // the discarded slot counts as the second cycle
            skip_pending <= 1'b0; // [RULE6]
            skip_cycles <= albo_pkg::ALBO_SKIP_CYCLES;
        end
        else if (exec && cmd_op == albo_pkg::ALBO_OP_TEST_SKIP)
        begin
            skip_pending <= alu_bus.bit_clear; // [RULE6]
            skip_cycles <= alu_bus.bit_clear ? 2'h1 : 2'h1;
        end
    end

    // read data mux; unmapped addresses read zero
    always_comb
    begin
        next_dat = 32'h0000_0000;
        if (WB_ADR_I == albo_pkg::ALBO_OFF_ACCUM)
            next_dat[7:0] = accum;
        else if (WB_ADR_I == albo_pkg::ALBO_OFF_FLAGS)
        begin
            next_dat[albo_pkg::ALBO_FLAG_CARRY] = carry_flag;
            next_dat[albo_pkg::ALBO_FLAG_DIGIT] = digit_carry_flag;
            next_dat[albo_pkg::ALBO_FLAG_ZERO] = zero_flag;
            next_dat[albo_pkg::ALBO_FLAG_SKIP] = skip_pending;
            next_dat[5:4] = skip_cycles;
        end
        else if (file_hit)
            next_dat[7:0] = file_reg[file_idx];
    end

    // registered read data and mirrored state outputs
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            WB_DAT_O <= 32'h0000_0000;
            ACCUM <= albo_pkg::ALBO_RST_ACCUM;
            FLAGS <= albo_pkg::ALBO_RST_FLAGS;
            SKIP_ACTIVE <= 1'b0;
        end
        else
        begin
            WB_DAT_O <= req ? next_dat : WB_DAT_O;
            ACCUM <= accum;
            FLAGS <= {zero_flag, digit_carry_flag, carry_flag};
            SKIP_ACTIVE <= skip_pending;
        end
    end

    assign WB_ACK_O = ack;
endmodule : albo_core

`default_nettype wire

// >>> test/albo_core_props.sv
/*
 * concurrent checks on the datapath top ports.
 * assumes: bound onto albo_core, one clock, sync active-high reset.
 */
`timescale 1ns/1ns
`default_nettype none

module albo_core_props
(
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic [7:0] ACCUM,
    input wire logic [2:0] FLAGS,
    input wire logic SKIP_ACTIVE
);
    // command write accepted this edge
    wire logic take = WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I
        && WB_ADR_I == albo_pkg::ALBO_OFF_CMD;
    wire logic [2:0] op = WB_DAT_I[2:0]; // opcode field
    wire logic live = take && !SKIP_ACTIVE; // not a discarded slot
    // mirrors lag one cycle, so effects are judged two edges on
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    property p_ack_take;
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O;
    endproperty
    a_ack_take: assert property (p_ack_take) else $error("ack timing");
    property p_rd_upper;
        WB_ACK_O && !WB_WE_I |-> WB_DAT_O[31:8] == 24'h00_0000;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("read upper bits");
    property p_rst;
        disable iff (1'b0) SYS_RST ##1 SYS_RST |-> ACCUM == 8'h00
            && FLAGS == 3'h0 && !SKIP_ACTIVE;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    property p_and_lit;
        live && op == albo_pkg::ALBO_OP_AND_LIT |=> ##1
            ACCUM == ($past(ACCUM, 2) & $past(WB_DAT_I[23:16], 2))
            && FLAGS[2] == (ACCUM == 8'h00)
            && FLAGS[1:0] == $past(FLAGS[1:0], 2);
    endproperty
    a_and_lit: assert property (p_and_lit) else $error("and literal");
    property p_zero_acc;
        live && !WB_DAT_I[3] && op inside {albo_pkg::ALBO_OP_ADD_FILE,
            albo_pkg::ALBO_OP_AND_FILE} |=> ##1 FLAGS[2] == (ACCUM == 8'h00);
    endproperty
    a_zero_acc: assert property (p_zero_acc) else $error("zero flag");
    property p_file_dest;
        live && WB_DAT_I[3] && op inside {albo_pkg::ALBO_OP_ADD_FILE,
            albo_pkg::ALBO_OP_AND_FILE} |=> ##1 ACCUM == $past(ACCUM, 2);
    endproperty
    a_file_dest: assert property (p_file_dest) else $error("dest");
    property p_bit_flags;
        live && op inside {albo_pkg::ALBO_OP_CLR_BIT, albo_pkg::ALBO_OP_SET_BIT,
            albo_pkg::ALBO_OP_TEST_SKIP} |=> ##1 FLAGS == $past(FLAGS, 2);
    endproperty
    a_bit_flags: assert property (p_bit_flags) else $error("bit op flags");
    property p_skip_rise;
        $rose(SKIP_ACTIVE) |-> $past(live && op == albo_pkg::ALBO_OP_TEST_SKIP)
            || $past(live && op == albo_pkg::ALBO_OP_TEST_SKIP, 2);
    endproperty
    a_skip_rise: assert property (p_skip_rise) else $error("stray skip");
    property p_skip_eat;
        take && SKIP_ACTIVE |=> ##1 ACCUM == $past(ACCUM, 2)
            && FLAGS == $past(FLAGS, 2) && !SKIP_ACTIVE;
    endproperty
    a_skip_eat: assert property (p_skip_eat) else $error("skip slot");
endmodule : albo_core_props

bind albo_core albo_core_props u_props (.CLK_SYS(CLK_SYS),
    .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .ACCUM(ACCUM), .FLAGS(FLAGS), .SKIP_ACTIVE(SKIP_ACTIVE));

`default_nettype wire

// >>> test/albo_core_tb.sv
/*
 * self-checking bench: wishbone tasks drive commands and read back.
 * assumes: albo_core with 32 file registers, ack one cycle after take.
 */
`timescale 1ns/1ns
`default_nettype none

module albo_core_tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat_w = 32'h0000_0000;
    logic [31:0] dat_r;
    logic ack;
    logic [7:0] accum;
    logic [2:0] flags;
    logic skip;
    logic [31:0] rd; // last read data
    int failures = 0;
    int cmp_count = 0;

    albo_core dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(dat_w),
        .WB_SEL_I(4'h1), .WB_DAT_O(dat_r), .WB_ACK_O(ack), .ACCUM(accum),
        .FLAGS(flags), .SKIP_ACTIVE(skip));

    // 50 ns period
    always #25 clk_sys = ~clk_sys;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check

    // one classic cycle; held until ack is sampled, bounded wait
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        rd = dat_r;
        if (ack !== 1'b1)
            failures++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask : rd_chk

    // only carry, digit carry and zero are compared
    task automatic flag_chk(input logic [2:0] exp);
        xfer(1'b0, albo_pkg::ALBO_OFF_FLAGS, 32'h0000_0000);
        check({29'h0, rd[2:0]}, {29'h0, exp});
    endtask : flag_chk

    task automatic cmd(input albo_pkg::albo_op_t op, input logic dst,
        input logic [2:0] b, input logic [4:0] f, input logic [7:0] lit);
        xfer(1'b1, albo_pkg::ALBO_OFF_CMD,
            {8'h00, lit, 3'h0, f, 1'b0, b, dst, op});
    endtask : cmd

    function automatic logic [7:0] fa(input logic [4:0] f);
        return {1'b1, f, 2'b00};
    endfunction : fa

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // watchdog: far beyond the few hundred cycles the tests need
    initial
    begin
        #250000;
        failures++;
        tally_and_finish();
    end

    initial
    begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd_chk(albo_pkg::ALBO_OFF_ACCUM, 32'h0000_0000);
        flag_chk(3'h0);
        rd_chk(8'h40, 32'h0000_0000);
        xfer(1'b1, albo_pkg::ALBO_OFF_ACCUM, 32'h0000_000F);
        xfer(1'b1, fa(5'd31), 32'h0000_0001);
        cmd(albo_pkg::ALBO_OP_ADD_FILE, 1'b0, 3'h0, 5'd31, 8'h00);
        rd_chk(albo_pkg::ALBO_OFF_ACCUM, 32'h0000_0010);
        flag_chk(3'h2);
        xfer(1'b1, fa(5'd5), 32'h0000_00F0);
        cmd(albo_pkg::ALBO_OP_ADD_FILE, 1'b1, 3'h0, 5'd5, 8'h00);
        rd_chk(fa(5'd5), 32'h0000_0000);
        rd_chk(albo_pkg::ALBO_OFF_ACCUM, 32'h0000_0010);
        flag_chk(3'h5);
        cmd(albo_pkg::ALBO_OP_AND_LIT, 1'b0, 3'h0, 5'd0, 8'h30);
        flag_chk(3'h1);
        cmd(albo_pkg::ALBO_OP_AND_LIT, 1'b0, 3'h0, 5'd0, 8'hEF);
        rd_chk(albo_pkg::ALBO_OFF_ACCUM, 32'h0000_0000);
        flag_chk(3'h5);
        xfer(1'b1, albo_pkg::ALBO_OFF_ACCUM, 32'h0000_00FF);
        xfer(1'b1, fa(5'd2), 32'h0000_005A);
        cmd(albo_pkg::ALBO_OP_AND_FILE, 1'b1, 3'h0, 5'd2, 8'h00);
        rd_chk(albo_pkg::ALBO_OFF_ACCUM, 32'h0000_00FF);
        flag_chk(3'h1);
        cmd(albo_pkg::ALBO_OP_AND_FILE, 1'b0, 3'h0, 5'd2, 8'h00);
        repeat (2) @(posedge clk_sys);
        check({24'h00_0000, accum}, 32'h0000_005A);
        for (int i = 0; i < 8; i++)
        begin
            cmd(albo_pkg::ALBO_OP_SET_BIT, 1'b0, 3'(i), 5'd7, 8'h00);
            rd_chk(fa(5'd7), (32'h0000_0002 << i) - 1);
        end
        for (int i = 0; i < 8; i++)
        begin
            cmd(albo_pkg::ALBO_OP_CLR_BIT, 1'b0, 3'(i), 5'd7, 8'h00);
            rd_chk(fa(5'd7), (32'h0000_00FF << (i + 1)) & 32'h0000_00FF);
        end
        flag_chk(3'h1);
        cmd(albo_pkg::ALBO_OP_TEST_SKIP, 1'b0, 3'h3, 5'd7, 8'h00);
        repeat (2) @(posedge clk_sys);
        check({31'h0, skip}, 32'h0000_0001);
        cmd(albo_pkg::ALBO_OP_AND_LIT, 1'b0, 3'h0, 5'd0, 8'h00);
        rd_chk(albo_pkg::ALBO_OFF_ACCUM, 32'h0000_005A);
        cmd(albo_pkg::ALBO_OP_SET_BIT, 1'b0, 3'h3, 5'd7, 8'h00);
        cmd(albo_pkg::ALBO_OP_TEST_SKIP, 1'b0, 3'h3, 5'd7, 8'h00);
        cmd(albo_pkg::ALBO_OP_AND_LIT, 1'b0, 3'h0, 5'd0, 8'h0F);
        rd_chk(albo_pkg::ALBO_OFF_ACCUM, 32'h0000_000A);
        flag_chk(3'h1);
        // second reset in mid-run must clear file registers too
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd_chk(fa(5'd7), 32'h0000_0000);
        rd_chk(albo_pkg::ALBO_OFF_ACCUM, 32'h0000_0000);
        tally_and_finish();
    end
endmodule : albo_core_tb

`default_nettype wire
